// ---- ngw_pkg.sv ----
// shared constants and state types for the nibble port block
package ngw_pkg;
    localparam int ADDR_W = 10;
    localparam int NIB = 4;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_COMBO_DIR = 8'h01;
    localparam logic [7:0] IDX_COMBO_DATA = 8'h04;
    localparam logic [7:0] IDX_PORT_B_DIR = 8'h05;
    localparam logic [7:0] IDX_PORT_D_DIR = 8'h0C;
    localparam logic [7:0] IDX_PORT_E_DATA = 8'h0E;
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h10;
    localparam logic [7:0] IDX_PORT_D_DATA = 8'h11;
    localparam logic [7:0] IDX_OPTION = 8'h12;
    localparam logic [7:0] IDX_WAKE_EN = 8'h13;
    localparam logic [7:0] IDX_PD50K = 8'h14;
    localparam logic [7:0] IDX_PD1M = 8'h15;
    localparam logic [7:0] IDX_WAKE_CAUSE = 8'h16;
    // option register bit positions
    localparam int OPT_COMBO_IO = 0;
    localparam int OPT_SEL_E = 1;
    localparam int OPT_CMP1 = 2;
    localparam int OPT_CMP2 = 3;
    localparam int OPT_OPAMP = 4;
    localparam int OPT_P1RZ = 5;
    localparam int OPT_P3RZ = 6;
    localparam int OPT_DUAL = 7;
    localparam int OPT_W = 8;
    // reset values
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [OPT_W-1:0] RST_OPT = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_PD = 12'h000;
    localparam logic [11:0] WAKE_VECTOR = 12'h004;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_idx;
        logic [11:0] w_nib;
        logic w_lane;
        logic [3:0] b_dir;
        logic [3:0] b_lat;
        logic [3:0] d_dir;
        logic [3:0] d_lat;
        logic [3:0] ce_dir;
        logic [3:0] ce_lat;
        logic [OPT_W-1:0] opt;
        logic [7:0] wake_en;
        logic [11:0] pd50k;
        logic [11:0] pd1m;
        logic [7:0] cause;
        logic halted;
        logic osc_run;
        logic pc_load;
        logic [11:0] pc_vec;
        logic [3:0] b_oe_n;
        logic [3:0] d_oe_n;
        logic [3:0] ce_oe_n;
        logic [3:0] ce_out;
        logic [11:0] pd50k_on;
        logic [11:0] pd1m_on;
        logic cmp1_en;
        logic cmp2_en;
        logic opamp_en;
    } ngw_state_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] prev;
    } ngw_sync_state_t;
endpackage

// ---- ngw_sync_if.sv ----
// carrier between a synchroniser and the port logic
`timescale 1ns/1ps
interface ngw_sync_if;
    logic [3:0] raw;
    logic [3:0] level;
    logic [3:0] rise;
    logic [3:0] fall;
    modport sync (input raw, output level, rise, fall);
    modport user (output raw, input level, rise, fall);
endinterface

// ---- ngw_sync_edge.sv ----
// two-flop synchroniser with edge detection for one nibble
`timescale 1ns/1ps
module ngw_sync_edge
    import ngw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    ngw_sync_if.sync port
);
    import ngw_pkg::*;

    ngw_sync_state_t s;
    ngw_sync_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.s1 = port.raw;
        next_s.s2 = s.s1;
        next_s.prev = s.s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // edges compare the synchronised level with its previous sample
    assign port.level = s.s2;
    assign port.rise = s.s2 & ~s.prev;
    assign port.fall = ~s.s2 & s.prev;
endmodule

// ---- ngw_ports.sv ----
// nibble ports B, D, C/E/CE with wake-up, behind an AXI4-Lite slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - port B direction: 1 output, reset zero
// - port D direction: 1 output, reset zero
// - combo direction only under combo I/O option
// - output pins: write drives, read returns latch
// - pull-downs off on every output pin
// - input read returns pin; pull-down per option
// - port B wake per pin by option
// - halted edge restarts oscillator, loads wake vector
// - port C output only, latch drives, reset zero
// - port E input only, reads pins, pull-downs
// - combo data resets zero, writes update latch
// - three analog modes from op-amp, comparator options
// - no analog option: plain bidirectional combo port
// - comparator one: bit0 comparator, bit1 pin
// - pin1 read-zero with comparator one: bit1 zero
// - pin3 read-zero acts on bit3 likewise
// - each comparator enabled by its own option; comparator two is also held off while the op-amp option is set
// - dual-edge option wakes on both edges
module ngw_ports
    import ngw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [ngw_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ngw_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_req,
    output logic osc_run,
    output logic wake_pc_load,
    output logic [11:0] wake_pc,
    input wire logic [3:0] port_b_in,
    output logic [3:0] port_b_out,
    output logic [3:0] port_b_oe_n,
    input wire logic [3:0] port_d_in,
    output logic [3:0] port_d_out,
    output logic [3:0] port_d_oe_n,
    input wire logic [3:0] combo_in,
    output logic [3:0] combo_out,
    output logic [3:0] combo_oe_n,
    output logic [11:0] pd50k_on,
    output logic [11:0] pd1m_on,
    input wire logic cmp1_out,
    input wire logic cmp2_out,
    output logic cmp1_en,
    output logic cmp2_en,
    output logic opamp_en
);
    import ngw_pkg::*;

    ngw_state_t s;
    ngw_state_t next_s;

    ngw_sync_if b_if ();
    ngw_sync_if d_if ();
    ngw_sync_if ce_if ();
    ngw_sync_if cmp_if ();

    assign b_if.raw = port_b_in;
    assign d_if.raw = port_d_in;
    assign ce_if.raw = combo_in;
    assign cmp_if.raw = {2'b00, cmp2_out, cmp1_out};

    ngw_sync_edge u_sync_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .port(b_if.sync)
    );
    ngw_sync_edge u_sync_d (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .port(d_if.sync)
    );
    ngw_sync_edge u_sync_ce (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .port(ce_if.sync)
    );
    ngw_sync_edge u_sync_cmp (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .port(cmp_if.sync)
    );

    // option decode
    logic io_mode;
    logic sel_e;
    logic cmp1_on;
    logic cmp2_on;
    logic op_on;
    logic [3:0] ce_dir_eff;
    logic [3:0] b_read;
    logic [3:0] d_read;
    logic [3:0] ce_read;
    logic [7:0] wake_ev;
    logic [7:0] dual_mask;

    always_comb begin
        io_mode = s.opt[OPT_COMBO_IO];
        sel_e = s.opt[OPT_SEL_E];
        cmp1_on = s.opt[OPT_CMP1];
        // comparator two is not part of the comparator plus op-amp mode
        cmp2_on = s.opt[OPT_CMP2] & ~s.opt[OPT_OPAMP];
        op_on = s.opt[OPT_OPAMP];
        if (io_mode) begin
            ce_dir_eff = s.ce_dir;
        end else if (sel_e) begin
            ce_dir_eff = 4'h0;
        end else begin
            ce_dir_eff = 4'hF;
        end
    end

    // read-back: latch on outputs, synchronised pin on inputs
    always_comb begin
        b_read = (s.b_dir & s.b_lat) | (~s.b_dir & b_if.level);
        d_read = (s.d_dir & s.d_lat) | (~s.d_dir & d_if.level);
        ce_read = (ce_dir_eff & s.ce_lat) | (~ce_dir_eff & ce_if.level);
        if (cmp1_on) begin
            ce_read[0] = cmp_if.level[0];
            ce_read[1] = s.opt[OPT_P1RZ] ? 1'b0 : ce_if.level[1];
        end
        if (cmp2_on) begin
            ce_read[2] = cmp_if.level[1];
            ce_read[3] = s.opt[OPT_P3RZ] ? 1'b0 : ce_if.level[3];
        end
        if (cmp1_on && op_on) begin
            // op-amp owns pins 2 and 3 in the mixed mode
            ce_read[2] = 1'b0;
            ce_read[3] = 1'b0;
        end
    end

    // wake events: rising edges, plus falling ones under the dual option
    always_comb begin
        dual_mask = s.opt[OPT_DUAL] ? 8'hFF : 8'h00;
        wake_ev = s.wake_en & ({d_if.rise, b_if.rise}
            | (dual_mask & {d_if.fall, b_if.fall}));
    end

    logic [7:0] cause_clr;
    logic [3:0] rd_nib;
    logic rd_ok;
    logic [7:0] rd_idx;

    always_comb begin
        rd_idx = s_axi_araddr[9:2];
        rd_ok = 1'b1;
        rd_nib = 4'h0;
        case (rd_idx)
            IDX_COMBO_DIR: rd_nib = s.ce_dir;
            IDX_COMBO_DATA: rd_nib = io_mode ? ce_read : s.ce_lat;
            IDX_PORT_B_DIR: rd_nib = s.b_dir;
            IDX_PORT_D_DIR: rd_nib = s.d_dir;
            IDX_PORT_E_DATA: rd_nib = io_mode ? ce_read : ce_if.level;
            IDX_PORT_B_DATA: rd_nib = b_read;
            IDX_PORT_D_DATA: rd_nib = d_read;
            IDX_OPTION: rd_nib = s.opt[3:0];
            IDX_WAKE_EN: rd_nib = s.wake_en[3:0];
            IDX_PD50K: rd_nib = s.pd50k[3:0];
            IDX_PD1M: rd_nib = s.pd1m[3:0];
            IDX_WAKE_CAUSE: rd_nib = s.cause[3:0];
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.pc_load = 1'b0;
        cause_clr = 8'h00;

        // write address and data may arrive in either order
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_got = 1'b1;
            next_s.aw_idx = s_axi_awaddr[9:2];
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_got = 1'b1;
            // option and wake bits sit above the nibble and the pull-down registers are twelve wide, so twelve bits are kept
            next_s.w_nib = s_axi_wdata[11:0];
            next_s.w_lane = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            case (s.aw_idx)
                IDX_COMBO_DIR: begin
                    if (s.w_lane) next_s.ce_dir = s.w_nib[3:0];
                end
                IDX_COMBO_DATA: begin
                    if (s.w_lane) next_s.ce_lat = s.w_nib[3:0];
                end
                IDX_PORT_B_DIR: begin
                    if (s.w_lane) next_s.b_dir = s.w_nib[3:0];
                end
                IDX_PORT_D_DIR: begin
                    if (s.w_lane) next_s.d_dir = s.w_nib[3:0];
                end
                IDX_PORT_E_DATA: begin
                    // input only: write accepted and discarded
                end
                IDX_PORT_B_DATA: begin
                    if (s.w_lane) next_s.b_lat = s.w_nib[3:0];
                end
                IDX_PORT_D_DATA: begin
                    if (s.w_lane) next_s.d_lat = s.w_nib[3:0];
                end
                IDX_OPTION: begin
                    if (s.w_lane) next_s.opt = s.w_nib[OPT_W-1:0];
                end
                IDX_WAKE_EN: begin
                    if (s.w_lane) next_s.wake_en = s.w_nib[7:0];
                end
                IDX_PD50K: begin
                    if (s.w_lane) next_s.pd50k = s.w_nib;
                end
                IDX_PD1M: begin
                    if (s.w_lane) next_s.pd1m = s.w_nib;
                end
                IDX_WAKE_CAUSE: begin
                    if (s.w_lane) cause_clr = s.w_nib[7:0];
                end
                default: next_s.bresp = RESP_SLVERR;
            endcase
        end

        // read channel answers one cycle after the address is taken
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s.arready && s_axi_arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = {28'h0000000, rd_nib};
            next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // halt entry from the core; a wake only counts once halted
        if (halt_req && !s.halted) begin
            next_s.halted = 1'b1;
        end
        if (s.halted && (|wake_ev)) begin
            next_s.halted = 1'b0;
            next_s.pc_load = 1'b1;
        end
        // set wins over a simultaneous write-one clear
        next_s.cause = (s.cause & ~cause_clr)
            | (s.halted ? wake_ev : 8'h00);
        next_s.osc_run = ~next_s.halted;
        next_s.pc_vec = WAKE_VECTOR;

        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;

        // pin drivers and pull-down gating follow the registers
        next_s.b_oe_n = ~next_s.b_dir;
        next_s.d_oe_n = ~next_s.d_dir;
        if (next_s.opt[OPT_COMBO_IO]) begin
            next_s.ce_oe_n = ~next_s.ce_dir;
        end else if (next_s.opt[OPT_SEL_E]) begin
            next_s.ce_oe_n = 4'hF;
        end else begin
            next_s.ce_oe_n = 4'h0;
        end
        next_s.ce_out = next_s.ce_lat;
        next_s.pd50k_on = next_s.pd50k
            & ~{~next_s.ce_oe_n, next_s.d_dir, next_s.b_dir};
        next_s.pd1m_on = next_s.pd1m
            & ~{~next_s.ce_oe_n, next_s.d_dir, next_s.b_dir};
        next_s.cmp1_en = next_s.opt[OPT_CMP1];
        next_s.cmp2_en = next_s.opt[OPT_CMP2] & ~next_s.opt[OPT_OPAMP];
        next_s.opamp_en = next_s.opt[OPT_OPAMP];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.pc_vec <= WAKE_VECTOR;
            s.osc_run <= 1'b1;
            s.b_oe_n <= 4'hF;
            s.d_oe_n <= 4'hF;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign osc_run = s.osc_run;
    assign wake_pc_load = s.pc_load;
    assign wake_pc = s.pc_vec;
    assign port_b_out = s.b_lat;
    assign port_b_oe_n = s.b_oe_n;
    assign port_d_out = s.d_lat;
    assign port_d_oe_n = s.d_oe_n;
    assign combo_out = s.ce_out;
    assign combo_oe_n = s.ce_oe_n;
    assign pd50k_on = s.pd50k_on;
    assign pd1m_on = s.pd1m_on;
    assign cmp1_en = s.cmp1_en;
    assign cmp2_en = s.cmp2_en;
    assign opamp_en = s.opamp_en;
endmodule

// ---- ngw_ports_sva.sv ----
// concurrent checks on the nibble port block's top-level ports
`timescale 1ns/1ps
module ngw_ports_sva
    import ngw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_run,
    input wire logic wake_pc_load,
    input wire logic [11:0] wake_pc,
    input wire logic [3:0] port_b_oe_n,
    input wire logic [3:0] port_d_oe_n,
    input wire logic [11:0] pd50k_on,
    input wire logic [11:0] pd1m_on
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wake;
        wake_pc == WAKE_VECTOR ##[0:1] osc_run;
    endsequence
    property p_wr_resp;
        s_wr_take |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_rd_next;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    property p_r_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_slverr_zero;
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == RST_WORD;
    endproperty
    property p_wake_pulse;
        wake_pc_load |=> !wake_pc_load;
    endproperty
    property p_wake_vec;
        wake_pc_load |-> s_wake;
    endproperty
    property p_pd_off_out;
        ((pd50k_on[7:0] | pd1m_on[7:0]) & ~{port_d_oe_n, port_b_oe_n}) == 8'h00;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    a_b_drop: assert property (p_b_drop)
        else $error("write response held after handshake");
    a_rd_next: assert property (p_rd_next)
        else $error("read data not next cycle");
    a_r_drop: assert property (p_r_drop)
        else $error("read data held after handshake");
    a_slverr_zero: assert property (p_slverr_zero)
        else $error("error read carries data");
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake load longer than one cycle");
    a_wake_vec: assert property (p_wake_vec)
        else $error("wake vector or oscillator wrong");
    a_pd_off_out: assert property (p_pd_off_out)
        else $error("pull-down on a driven pin");
endmodule
bind ngw_ports ngw_ports_sva u_sva (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_run, .wake_pc_load,
    .wake_pc, .port_b_oe_n, .port_d_oe_n, .pd50k_on, .pd1m_on);

// ---- ngw_pins.sv ----
// board side of the pins: driven level where enabled, else board value
`timescale 1ns/1ps
module ngw_pins (
    input wire logic [3:0] b_out,
    input wire logic [3:0] b_oe_n,
    input wire logic [3:0] d_out,
    input wire logic [3:0] d_oe_n,
    input wire logic [3:0] c_out,
    input wire logic [3:0] c_oe_n,
    input wire logic [3:0] ext_b,
    input wire logic [3:0] ext_d,
    input wire logic [3:0] ext_c,
    output logic [3:0] b_in,
    output logic [3:0] d_in,
    output logic [3:0] c_in
);
    // driver wins over the board; board never fights an output
    assign b_in = (b_out & ~b_oe_n) | (ext_b & b_oe_n);
    assign d_in = (d_out & ~d_oe_n) | (ext_d & d_oe_n);
    assign c_in = (c_out & ~c_oe_n) | (ext_c & c_oe_n);
endmodule

// ---- tb.sv ----
// self-checking bench for the nibble port block
`timescale 1ns/1ps
module tb;
    import ngw_pkg::*;
    typedef struct packed {
        logic [7:0] ix;
        logic [3:0] wd;
        logic [3:0] rd;
    } ngw_row_t;
    logic aclk, aresetn, halt_req, cmp1_out, osc_run, pc_load;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp, rr;
    logic [11:0] wake_pc, pd50k, pd1m;
    logic [3:0] b_in, b_out, b_oe_n, d_in, d_out, d_oe_n;
    logic [3:0] c_in, c_out, c_oe_n, ext_b, ext_d, ext_c;
    logic cmp1_en, cmp2_en, opamp_en;
    int num_errors, cmp_count, n;
    logic [7:0] rst_ix [4] = '{IDX_PORT_B_DIR, IDX_PORT_D_DIR,
        IDX_COMBO_DIR, IDX_COMBO_DATA};
    ngw_row_t rows [5] = '{'{IDX_PORT_B_DIR, 4'hF, 4'hF},
        '{IDX_PORT_D_DIR, 4'hA, 4'hA}, '{IDX_PORT_B_DATA, 4'h5, 4'h5},
        '{IDX_PORT_D_DATA, 4'h6, 4'h2}, '{IDX_PD50K, 4'hF, 4'hF}};

    ngw_ports DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .halt_req(halt_req),
        .osc_run(osc_run), .wake_pc_load(pc_load), .wake_pc(wake_pc),
        .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oe_n),
        .port_d_in(d_in), .port_d_out(d_out), .port_d_oe_n(d_oe_n),
        .combo_in(c_in), .combo_out(c_out), .combo_oe_n(c_oe_n),
        .pd50k_on(pd50k), .pd1m_on(pd1m), .cmp1_out(cmp1_out),
        .cmp2_out(1'b0), .cmp1_en(cmp1_en), .cmp2_en(cmp2_en),
        .opamp_en(opamp_en));
    ngw_pins u_pins (.b_out(b_out), .b_oe_n(b_oe_n), .d_out(d_out),
        .d_oe_n(d_oe_n), .c_out(c_out), .c_oe_n(c_oe_n), .ext_b(ext_b),
        .ext_d(ext_d), .ext_c(ext_c), .b_in(b_in), .d_in(d_in),
        .c_in(c_in));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task end_of_test;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // address and data offered together, each dropped when taken
    task wr(input logic [7:0] ix, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= {ix, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] ix);
        @(posedge aclk);
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end

    initial begin
        {aresetn, halt_req, cmp1_out, awvalid, wvalid, bready} <= '0;
        {arvalid, rready, awaddr, araddr, wdata} <= '0;
        {ext_b, ext_d, ext_c} <= '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        foreach (rst_ix[i]) begin
            rd(rst_ix[i]);
            chk("reset value", RST_WORD, rv);
        end
        chk("b oe_n reset", 32'hF, 32'(b_oe_n));
        wr(IDX_COMBO_DATA, 32'h9);
        repeat (2) @(posedge aclk);
        chk("port c out", 32'h9, 32'(c_out));
        chk("port c oe_n", 32'h0, 32'(c_oe_n));
        $display("reset and port c done");
        foreach (rows[i]) begin
            wr(rows[i].ix, 32'(rows[i].wd));
            rd(rows[i].ix);
            chk("row read", 32'(rows[i].rd), rv);
        end
        chk("b out", 32'h5, 32'(b_out));
        chk("b oe_n out", 32'h0, 32'(b_oe_n));
        chk("b pd out", 32'h0, 32'(pd50k[3:0]));
        $display("register rows done");
        wr(IDX_PORT_B_DIR, 32'h0);
        ext_b <= 4'hC;
        repeat (4) @(posedge aclk);
        chk("b pd in", 32'hF, 32'(pd50k[3:0]));
        rd(IDX_PORT_B_DATA);
        chk("b pin read", 32'hC, rv);
        $display("input mode done");
        wr(IDX_WAKE_EN, 32'h1);
        @(posedge aclk);
        halt_req <= 1'b1;
        @(posedge aclk);
        halt_req <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("halted", 32'h0, 32'(osc_run));
        // a rise on a pin without wake enable must leave it halted
        ext_b <= 4'hE;
        repeat (8) @(posedge aclk);
        chk("no wake", 32'h0, 32'(osc_run));
        ext_b <= 4'hF;
        n = 0;
        while (pc_load !== 1'b1 && n < 10) begin
            @(posedge aclk);
            n++;
        end
        chk("wake load", 32'h1, 32'(pc_load));
        chk("wake pc", 32'(WAKE_VECTOR), 32'(wake_pc));
        @(posedge aclk);
        chk("osc after wake", 32'h1, 32'(osc_run));
        $display("wake done");
        wr(IDX_OPTION, 32'h1);
        wr(IDX_COMBO_DIR, 32'h0);
        ext_c <= 4'hA;
        cmp1_out <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("combo oe_n", 32'hF, 32'(c_oe_n));
        rd(IDX_COMBO_DATA);
        chk("combo plain", 32'hA, rv);
        wr(IDX_OPTION, 32'h5);
        repeat (4) @(posedge aclk);
        rd(IDX_COMBO_DATA);
        chk("combo cmp1", 32'hB, rv);
        chk("cmp1 en", 32'h1, 32'(cmp1_en));
        chk("cmp2 en", 32'h0, 32'(cmp2_en));
        wr(IDX_OPTION, 32'h25);
        repeat (4) @(posedge aclk);
        rd(IDX_COMBO_DATA);
        chk("combo p1 zero", 32'h9, rv);
        wr(IDX_OPTION, 32'h2);
        repeat (4) @(posedge aclk);
        rd(IDX_PORT_E_DATA);
        chk("port e read", 32'hA, rv);
        $display("combo done");
        rd(8'h30);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rr));
        chk("unmapped rdata", RST_WORD, rv);
        wr(8'h30, 32'hF);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rr));
        $display("unmapped done");
        end_of_test();
    end
endmodule
